// file: src/ref_ctl_pkg.sv
// Package: register map, field positions, reset values and bus types of the reference control bank
package ref_ctl_pkg;

    // ------------------------------------------------------------------
    // Register indices (printed offsets) and byte-address width
    // ------------------------------------------------------------------
    localparam logic [11:0] IDX_REF_VALIDATION_SKIP     = 12'ha02;
    localparam logic [11:0] IDX_REF_FORCE_FAULT         = 12'ha03;
    localparam logic [11:0] IDX_REF_MONITOR_BYPASS      = 12'ha04;
    localparam logic [11:0] IDX_IRQ_GROUP_CLEAR         = 12'ha05;
    localparam logic [11:0] IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR = 12'ha06;
    localparam logic [11:0] IDX_IRQ_STATUS              = 12'ha10;
    localparam logic [11:0] IDX_IRQ_MASK                = 12'ha11;
    localparam logic [11:0] IDX_REF_STATE               = 12'ha12;
    localparam int          ADDR_W                      = 14;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int          NUM_REFS       = 4;
    localparam logic [7:0]  REF_FIELD_MASK = 8'h0f;
    localparam logic [7:0]  GROUP_MASK     = 8'hbf;
    localparam int          GRP_ALL        = 0;
    localparam int          GRP_COMMON     = 1;
    localparam int          GRP_LOOP0      = 2;
    localparam int          GRP_WATCHDOG   = 7;
    localparam int          SYS_UNLOCKED   = 7;
    localparam int          SYS_STABLE     = 6;
    localparam int          SYS_LOCKED     = 5;
    localparam int          SYS_CAL_ENDED  = 4;
    localparam int          SYS_CAL_START  = 3;
    localparam int          SYS_WATCHDOG   = 2;
    localparam int          SYS_EE_FAULT   = 1;
    localparam int          SYS_EE_DONE    = 0;

    // Local interrupt status bits
    localparam int          EV_VALIDATED   = 0;
    localparam int          EV_FAULTED     = 4;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_BYTE       = 8'h00;
    localparam logic [31:0] RST_WORD       = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [ADDR_W-1:0] paddr;
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [31:0]       pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [7:0] group;
        logic [7:0] system_clock_pll_eeprom;
    } irq_clear_t;

endpackage

// file: src/ref_sync3.sv
// Module: three-stage synchroniser for a bundle of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module ref_sync3 #(
    parameter int WIDTH = 4
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             rst,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    // ------------------------------------------------------------------
    // Chain; output moves only when stages two and three agree
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
        end
        else
        begin
            stage1 <= async_in;
            stage2 <= stage1;
            stage3 <= stage2;
        end
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_agree
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    sync_out[i] <= 1'b0;
                else if (stage2[i] == stage3[i])
                    sync_out[i] <= stage3[i];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: src/ref_qualify.sv
// Module: per-reference fault qualification from monitor, force and bypass controls
`timescale 1ns/1ps
`default_nettype none
module ref_qualify #(
    parameter int N = 4
) (
    // Clock and reset
    input  wire logic         ref_clk,
    input  wire logic         rst,
    // Controls
    input  wire logic [N-1:0] force_fault,
    input  wire logic [N-1:0] monitor_bypass,
    input  wire logic [N-1:0] monitor_fault,
    // Qualified state
    output logic      [N-1:0] ref_faulted
);

    // ------------------------------------------------------------------
    // Force wins over bypass; bypass hides the frequency monitor
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_ref
            always_ff @(posedge ref_clk or posedge rst)
            begin
                if (rst)
                    ref_faulted[i] <= 1'b0;
                else if (force_fault[i])
                    ref_faulted[i] <= 1'b1;
                else if (monitor_bypass[i])
                    ref_faulted[i] <= 1'b0;
                else
                    ref_faulted[i] <= monitor_fault[i];
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: src/ref_input_override_irq_clear.sv
// Module: reference override and interrupt clear register bank on APB
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Skip bit zeroes validation timer of unfaulted refs, self-clears
// - Force-fault bit faults and excludes reference
// - Bypass ignores monitor unless force-fault set
// - Writing one clears matching latched IRQ
// - Clear bits return to zero themselves
// - Clear bits mirror monitor register positions
// - Group bits: all, common, loops 0-3
// - Group bit 7 clears watchdog alert
// - Bits 7..3 clear system PLL events
// - Bit 2 clears watchdog expiry IRQ
// - Bits 1,0 clear EEPROM fault/complete
module ref_input_override_irq_clear #(
    parameter int NUM_REFS = ref_ctl_pkg::NUM_REFS
) (
    // Clock and reset
    input  wire logic                             ref_clk,
    input  wire logic                             rst,
    // APB slave
    input  wire logic [ref_ctl_pkg::ADDR_W-1:0]   paddr,
    input  wire logic                             psel,
    input  wire logic                             penable,
    input  wire logic                             pwrite,
    input  wire logic [31:0]                      pwdata,
    input  wire logic [3:0]                       pstrb,
    output logic      [31:0]                      prdata,
    output logic                                  pready,
    output logic                                  pslverr,
    // Reference monitors (pins, asynchronous)
    input  wire logic [NUM_REFS-1:0]              monitor_fault,
    input  wire logic [NUM_REFS-1:0]              ref_validated,
    // Reference qualification outputs
    output logic      [NUM_REFS-1:0]              validation_timer_zero,
    output logic      [NUM_REFS-1:0]              ref_faulted,
    // IRQ monitor latch clears
    output ref_ctl_pkg::irq_clear_t               irq_clear,
    // Interrupt
    output logic                                  irq
);

    ref_ctl_pkg::apb_req_t req;
    logic [NUM_REFS-1:0]   force_fault;
    logic [NUM_REFS-1:0]   monitor_bypass;
    logic [NUM_REFS-1:0]   fault_sync;
    logic [NUM_REFS-1:0]   valid_sync;
    logic [NUM_REFS-1:0]   qual_faulted;
    logic [NUM_REFS-1:0]   qual_faulted_d;
    logic [NUM_REFS-1:0]   valid_d;
    logic [7:0]            irq_status;
    logic [7:0]            irq_mask;
    logic [7:0]            irq_event;
    logic                  wr_go;
    logic                  rd_go;
    logic [11:0]           reg_idx;
    logic                  addr_ok;
    logic                  lane0;
    logic                  status_read;
    logic [31:0]           next_prdata;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    // Byte address is four times the index; low two bits must be zero
    function automatic logic mapped(input logic [11:0] idx);
        begin
            mapped = (idx == ref_ctl_pkg::IDX_REF_VALIDATION_SKIP) ||
                     (idx == ref_ctl_pkg::IDX_REF_FORCE_FAULT) ||
                     (idx == ref_ctl_pkg::IDX_REF_MONITOR_BYPASS) ||
                     (idx == ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR) ||
                     (idx == ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR) ||
                     (idx == ref_ctl_pkg::IDX_IRQ_STATUS) ||
                     (idx == ref_ctl_pkg::IDX_IRQ_MASK) ||
                     (idx == ref_ctl_pkg::IDX_REF_STATE);
        end
    endfunction

    // Write strobe of one register; every writable register shares it
    function automatic logic wr_hit(input logic [11:0] idx);
        begin
            wr_hit = wr_go && lane0 && (reg_idx == idx);
        end
    endfunction

    assign req.paddr   = paddr;
    assign req.psel    = psel;
    assign req.penable = penable;
    assign req.pwrite  = pwrite;
    assign req.pwdata  = pwdata;

    assign reg_idx = req.paddr[ref_ctl_pkg::ADDR_W-1:2];
    assign addr_ok = mapped(reg_idx) && (req.paddr[1:0] == 2'b00);
    // One wait state: pready rises in the second access cycle
    assign wr_go   = req.psel && req.penable && pready && req.pwrite && addr_ok;
    assign rd_go   = req.psel && req.penable && pready && !req.pwrite && addr_ok;
    assign lane0   = pstrb[0];

    // ------------------------------------------------------------------
    // Handshake
    // ------------------------------------------------------------------
    // One fixed wait state keeps read data a plain register stage
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pready <= 1'b0;
        else
            pready <= req.psel && req.penable && !pready;
    end

    // A bad address still completes, so a master never hangs
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            pslverr <= 1'b0;
        else
            pslverr <= req.psel && req.penable && !pready && !addr_ok;
    end

    // ------------------------------------------------------------------
    // Override registers
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            force_fault <= '0;
        else if (wr_hit(ref_ctl_pkg::IDX_REF_FORCE_FAULT))
            force_fault <= req.pwdata[NUM_REFS-1:0];
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            monitor_bypass <= '0;
        else if (wr_hit(ref_ctl_pkg::IDX_REF_MONITOR_BYPASS))
            monitor_bypass <= req.pwdata[NUM_REFS-1:0];
    end

    // Self-clearing: high for one cycle after a write of one
    // Faulted references are left alone; their timer runs on
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            validation_timer_zero <= '0;
        else if (wr_hit(ref_ctl_pkg::IDX_REF_VALIDATION_SKIP))
            validation_timer_zero <= req.pwdata[NUM_REFS-1:0] & ~qual_faulted;
        else
            validation_timer_zero <= '0;
    end

    // ------------------------------------------------------------------
    // Clear pulses to the IRQ monitor latches
    // ------------------------------------------------------------------
    // Pulse bits sit at the monitor's own positions, so no remap
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_clear.group <= ref_ctl_pkg::RST_BYTE;
        else if (wr_hit(ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR))
            irq_clear.group <= req.pwdata[7:0] & ref_ctl_pkg::GROUP_MASK;
        else
            irq_clear.group <= ref_ctl_pkg::RST_BYTE;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_clear.system_clock_pll_eeprom <= ref_ctl_pkg::RST_BYTE;
        else if (wr_hit(ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR))
            irq_clear.system_clock_pll_eeprom <= req.pwdata[7:0];
        else
            irq_clear.system_clock_pll_eeprom <= ref_ctl_pkg::RST_BYTE;
    end

    // ------------------------------------------------------------------
    // Reference qualification
    // ------------------------------------------------------------------
    // Pins pass four flops; a change counts once two stages agree
    ref_sync3 #(
        .WIDTH (2*NUM_REFS)
    ) u_sync (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .async_in ({ref_validated, monitor_fault}),
        .sync_out ({valid_sync, fault_sync})
    );

    ref_qualify #(
        .N (NUM_REFS)
    ) u_qualify (
        .ref_clk        (ref_clk),
        .rst            (rst),
        .force_fault    (force_fault),
        .monitor_bypass (monitor_bypass),
        .monitor_fault  (fault_sync),
        .ref_faulted    (qual_faulted)
    );

    // Extra stage so the port comes straight from a flop
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ref_faulted <= '0;
        else
            ref_faulted <= qual_faulted;
    end

    // ------------------------------------------------------------------
    // Local interrupt: validated and faulted edges per reference
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            qual_faulted_d <= '0;
            valid_d        <= '0;
        end
        else
        begin
            qual_faulted_d <= qual_faulted;
            valid_d        <= valid_sync;
        end
    end

    // Each event has a fixed slot in the status byte
    genvar r;
    generate
        for (r = 0; r < NUM_REFS; r++)
        begin : g_event
            assign irq_event[ref_ctl_pkg::EV_VALIDATED + r] = valid_sync[r] & ~valid_d[r];
            assign irq_event[ref_ctl_pkg::EV_FAULTED + r] = qual_faulted[r] & ~qual_faulted_d[r];
        end
    endgenerate
    assign status_read = rd_go && reg_idx == ref_ctl_pkg::IDX_IRQ_STATUS;

    // ------------------------------------------------------------------
    // Status and mask
    // ------------------------------------------------------------------
    // Set wins over the clear-on-read
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_status <= ref_ctl_pkg::RST_BYTE;
        else if (status_read)
            irq_status <= irq_event;
        else
            irq_status <= irq_status | irq_event;
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq_mask <= ref_ctl_pkg::RST_BYTE;
        else if (wr_hit(ref_ctl_pkg::IDX_IRQ_MASK))
            irq_mask <= req.pwdata[7:0];
    end

    // Dropped with the status read so a cleared request does not linger
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            irq <= 1'b0;
        else
            irq <= |(irq_status & irq_mask & ~({8{status_read}}));
    end

    // ------------------------------------------------------------------
    // Read data; clear registers read as zero
    // ------------------------------------------------------------------
    always_comb
    begin
        next_prdata = ref_ctl_pkg::RST_WORD;
        if (req.psel && req.penable && !pready && !req.pwrite)
        begin
            case (reg_idx)
                ref_ctl_pkg::IDX_REF_FORCE_FAULT:
                    next_prdata[NUM_REFS-1:0] = force_fault;
                ref_ctl_pkg::IDX_REF_MONITOR_BYPASS:
                    next_prdata[NUM_REFS-1:0] = monitor_bypass;
                // An event now would be lost to the clear, so it is reported at once
                ref_ctl_pkg::IDX_IRQ_STATUS:
                    next_prdata[7:0] = irq_status | irq_event;
                ref_ctl_pkg::IDX_IRQ_MASK:
                    next_prdata[7:0] = irq_mask;
                ref_ctl_pkg::IDX_REF_STATE:
                    next_prdata[2*NUM_REFS-1:0] = {valid_sync, qual_faulted};
                default:
                    next_prdata = ref_ctl_pkg::RST_WORD;
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            prdata <= ref_ctl_pkg::RST_WORD;
        else
            prdata <= next_prdata;
    end

endmodule
`default_nettype wire

// file: bench/ref_input_override_irq_clear_asserts.sv
// Checker: port-level assertions for the reference control bank
`timescale 1ns/1ps
`default_nettype none
module ref_input_override_irq_clear_chk #(
    parameter int NUM_REFS = 4
) (
    // Clock and reset
    input wire logic                           ref_clk,
    input wire logic                           rst,
    // APB
    input wire logic [ref_ctl_pkg::ADDR_W-1:0] paddr,
    input wire logic                           psel,
    input wire logic                           penable,
    input wire logic                           pwrite,
    input wire logic [31:0]                    pwdata,
    input wire logic [3:0]                     pstrb,
    input wire logic [31:0]                    prdata,
    input wire logic                           pready,
    input wire logic                           pslverr,
    // Reference side
    input wire logic [NUM_REFS-1:0]            monitor_fault,
    input wire logic [NUM_REFS-1:0]            ref_validated,
    input wire logic [NUM_REFS-1:0]            validation_timer_zero,
    input wire logic [NUM_REFS-1:0]            ref_faulted,
    input wire ref_ctl_pkg::irq_clear_t        irq_clear,
    input wire logic                           irq
);
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic [11:0]         idx;
    logic                wr_done;
    logic [NUM_REFS-1:0] force_shadow;
    logic [2:0]          force_age;
    assign idx = paddr[ref_ctl_pkg::ADDR_W-1:2];
    assign wr_done = psel && penable && pready && pwrite && pstrb[0] && !pslverr;

    // Age saturates so the fault check waits out the qualification latency
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            force_shadow <= '0;
            force_age    <= 3'h0;
        end
        else if (wr_done && idx == ref_ctl_pkg::IDX_REF_FORCE_FAULT)
        begin
            force_shadow <= pwdata[NUM_REFS-1:0];
            force_age    <= 3'h0;
        end
        else if (force_age != 3'h5)
            force_age <= force_age + 3'h1;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    a_clear_one_cycle: assert property (irq_clear != '0 |=> irq_clear == '0)
        else $error("clear pulse held too long");
    a_group_reserved_zero: assert property (irq_clear.group[6] == 1'b0)
        else $error("reserved group clear pulsed");
    a_sys_clear_data: assert property ((wr_done && idx == ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR)
        |=> irq_clear.system_clock_pll_eeprom == $past(pwdata[7:0])) else $error("system clear mismatch");
    a_group_clear_data: assert property ((wr_done && idx == ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR)
        |=> irq_clear.group == ($past(pwdata[7:0]) & ref_ctl_pkg::GROUP_MASK))
        else $error("group clear mismatch");
    a_clear_needs_write: assert property (irq_clear != '0 |-> $past(wr_done))
        else $error("clear pulse without write");
    a_skip_needs_write: assert property (validation_timer_zero != '0 |->
        $past(wr_done && idx == ref_ctl_pkg::IDX_REF_VALIDATION_SKIP)
        && (validation_timer_zero & ~$past(pwdata[NUM_REFS-1:0])) == '0)
        else $error("timer zero without write");
    a_force_faults: assert property (force_age == 3'h5 |->
        (ref_faulted & force_shadow) == force_shadow) else $error("forced reference not faulted");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error outside ready");
    a_clear_reads_zero: assert property ((pready && !pwrite
        && (idx == ref_ctl_pkg::IDX_REF_VALIDATION_SKIP || idx == ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR
        || idx == ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR)) |-> prdata == '0)
        else $error("clear register read nonzero");

    c_watchdog: cover property (irq_clear.group[ref_ctl_pkg::GRP_WATCHDOG]);
    c_timer_zero: cover property (validation_timer_zero != '0);
    c_irq: cover property (irq);
endmodule

bind ref_input_override_irq_clear ref_input_override_irq_clear_chk #(.NUM_REFS(NUM_REFS))
    ref_input_override_irq_clear_chk_i (
    .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .monitor_fault(monitor_fault), .ref_validated(ref_validated),
    .validation_timer_zero(validation_timer_zero), .ref_faulted(ref_faulted),
    .irq_clear(irq_clear), .irq(irq));
`default_nettype wire

// file: bench/ref_input_override_irq_clear_bench.sv
// Testbench: directed APB scenarios for the reference control bank
`timescale 1ns/1ps
`default_nettype none
module ref_input_override_irq_clear_bench;
    logic        ref_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [13:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0]  pstrb = '0, monitor_fault = '0, ref_validated = '0;
    logic [3:0]  vtz, ref_faulted, vtz1;
    logic        pready, pslverr, irq, er;
    logic [15:0] clr1, clr2;
    ref_ctl_pkg::irq_clear_t irq_clear;
    int          fail_count = 0, total_checks = 0, cycles = 0;

    ref_input_override_irq_clear ref_input_override_irq_clear_i (
        .ref_clk(ref_clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .monitor_fault(monitor_fault), .ref_validated(ref_validated),
        .validation_timer_zero(vtz), .ref_faulted(ref_faulted), .irq_clear(irq_clear),
        .irq(irq));

    always #10 ref_clk = ~ref_clk;

    // Cuts a hang short
    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            fail_count++;
            tally_and_finish();
        end
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Entered at a rising edge; pulses are caught in the cycle after completion
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d,
                       input logic [3:0] st);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= st;
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
        clr1 = irq_clear;
        vtz1 = vtz;
        @(posedge ref_clk);
        clr2 = irq_clear;
    endtask

    task automatic wr(input logic [11:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d, 4'h1);
    endtask

    task automatic rdreg(input logic [11:0] idx);
        apb(1'b0, idx, 8'h00, 4'h0);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_defaults;
        logic [11:0] regs [8] = '{12'ha02, 12'ha03, 12'ha04, 12'ha05, 12'ha06, 12'ha10,
                                  12'ha11, 12'ha12};
        for (int i = 0; i < 8; i++)
        begin
            rdreg(regs[i]);
            check(rd, ref_ctl_pkg::RST_WORD);
            check({31'h0, er}, 32'h0);
        end
        rdreg(12'h0ff);
        check({31'h0, er}, 32'h1);
        $display("test defaults done");
    endtask

    task automatic t_clears;
        for (int i = 0; i < 8; i++)
        begin
            wr(ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR, 8'h1 << i);
            check({16'h0, clr1}, {24'h0, 8'h1 << i});
            check({16'h0, clr2}, 32'h0);
            wr(ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR, 8'h1 << i);
            check({16'h0, clr1}, {16'h0, (8'h1 << i) & 8'hbf, 8'h00});
        end
        wr(ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR, 8'h00);
        check({16'h0, clr1}, 32'h0);
        apb(1'b1, ref_ctl_pkg::IDX_IRQ_GROUP_CLEAR, 8'hff, 4'h0);
        check({16'h0, clr1}, 32'h0);
        rdreg(ref_ctl_pkg::IDX_SYSTEM_CLOCK_PLL_EEPROM_IRQ_CLEAR);
        check(rd, 32'h0);
        $display("test clears done");
    endtask

    task automatic t_force_bypass;
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'hff);
        rdreg(ref_ctl_pkg::IDX_REF_FORCE_FAULT);
        check(rd, 32'h0f);
        idle(3);
        check(32'(ref_faulted), 32'hf);
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h05);
        idle(3);
        check(32'(ref_faulted), 32'h5);
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h00);
        monitor_fault <= 4'hf;
        idle(8);
        check(32'(ref_faulted), 32'hf);
        wr(ref_ctl_pkg::IDX_REF_MONITOR_BYPASS, 8'h03);
        idle(3);
        check(32'(ref_faulted), 32'hc);
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h01);
        idle(3);
        check(32'(ref_faulted), 32'hd);
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h00);
        wr(ref_ctl_pkg::IDX_REF_MONITOR_BYPASS, 8'h00);
        monitor_fault <= 4'h0;
        idle(8);
        check(32'(ref_faulted), 32'h0);
        $display("test force and bypass done");
    endtask

    task automatic t_skip;
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h01);
        idle(3);
        wr(ref_ctl_pkg::IDX_REF_VALIDATION_SKIP, 8'h0f);
        check(32'(vtz1), 32'he);
        rdreg(ref_ctl_pkg::IDX_REF_VALIDATION_SKIP);
        check(rd, 32'h0);
        wr(ref_ctl_pkg::IDX_REF_FORCE_FAULT, 8'h00);
        idle(3);
        wr(ref_ctl_pkg::IDX_REF_VALIDATION_SKIP, 8'h01);
        check(32'(vtz1), 32'h1);
        $display("test skip done");
    endtask

    task automatic t_irq;
        rdreg(ref_ctl_pkg::IDX_IRQ_STATUS);
        wr(ref_ctl_pkg::IDX_IRQ_MASK, 8'h01);
        ref_validated <= 4'h1;
        idle(8);
        check({31'h0, irq}, 32'h1);
        wr(ref_ctl_pkg::IDX_IRQ_MASK, 8'h00);
        idle(2);
        check({31'h0, irq}, 32'h0);
        rdreg(ref_ctl_pkg::IDX_IRQ_STATUS);
        check(rd, 32'h01);
        wr(ref_ctl_pkg::IDX_IRQ_MASK, 8'h01);
        idle(2);
        check({31'h0, irq}, 32'h0);
        ref_validated <= 4'h0;
        $display("test interrupt done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        t_defaults();
        t_clears();
        t_force_bypass();
        t_skip();
        t_irq();
        tally_and_finish();
    end
endmodule
`default_nettype wire
